// ===== src/egs_pkg.sv
package egs_pkg;

	// ****************************************************************
	// Register map
	// ****************************************************************
	localparam int          REG_AW         = 8;
	localparam logic [7:0]  OFS_NUM        = 8'h00;
	localparam logic [7:0]  OFS_DEN        = 8'h04;
	localparam logic [7:0]  OFS_CTRL       = 8'h08;
	localparam logic [7:0]  OFS_STAT       = 8'h0C;
	localparam logic [7:0]  OFS_ENC        = 8'h10;
	localparam logic [7:0]  OFS_ISTS       = 8'h14;
	localparam logic [7:0]  OFS_IMSK       = 8'h18;

	// ****************************************************************
	// Field positions and values after reset
	// ****************************************************************
	localparam int          CTRL_MEN_BIT     = 0;
	localparam int          CTRL_N_LSB       = 8;
	localparam int          CTRL_RESTART_BIT = 31;
	localparam int          STAT_OK_BIT      = 0;
	localparam int          STAT_ALARM_BIT   = 1;
	localparam int          STAT_BUSY_BIT    = 2;
	localparam int          IRQ_ALARM        = 0;
	localparam int          IRQ_DROP         = 1;
	localparam int          IRQ_W            = 2;
	localparam logic [31:0] NUM_RST          = 32'h0000_0040;
	localparam logic [31:0] DEN_RST          = 32'h0000_0001;
	localparam logic [31:0] PARAM_MAX        = 32'h4000_0000;
	localparam logic [63:0] RATIO_LO_MUL     = 64'h0000_0000_0000_03E8;
	localparam logic [63:0] RATIO_HI_MUL     = 64'h0000_0000_0000_FA00;

	// ****************************************************************
	// Encoder selection and resolution per turn
	// ****************************************************************
	localparam logic [1:0]  ENC_20           = 2'h0;
	localparam logic [1:0]  ENC_22           = 2'h1;
	localparam logic [1:0]  ENC_24           = 2'h2;
	localparam logic [31:0] RES_20           = 32'h0010_0000;
	localparam logic [31:0] RES_22           = 32'h0040_0000;
	localparam logic [31:0] RES_24           = 32'h0100_0000;

	// ****************************************************************
	// Types
	// ****************************************************************
	typedef enum logic [1:0] {ST_CHECK, ST_IDLE, ST_DIV} egs_state_e_t;

	typedef struct packed {
		logic [REG_AW-1:0] addr;
		logic [31:0]       wdata;
		logic              write;
		logic              read;
	} egs_bus_t;

	typedef struct packed {
		logic        valid;
		logic        dir;
		logic [31:0] count;
	} egs_fb_t;

	// Counts per turn for the selected encoder
	function automatic logic [31:0] egs_enc_res(input logic [1:0] sel);
		case (sel)
			ENC_22:  return RES_22;
			ENC_24:  return RES_24;
			default: return RES_20;
		endcase
	endfunction : egs_enc_res

endpackage : egs_pkg

// ===== src/egs_scaler.sv
// The address map and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
// What this block does, and how the host picks its ratio
// R1: Output pulses equal references times B over A
// R2: Ratio outside 0.001..64000 raises alarm, no gearing
// R3: Numerator 1..2^30, default 64, after restart
// R4: Denominator 1..2^30, default 1, after restart
// R5: Each reference pulse is one reference unit
// R6: Multiplication enabled: unit is n pulses
// R7: Host doing own scaling sets ratio 1:1
// R8: Encoder resolutions 2^20, 2^22, 2^24 counts
// R9: Direct linear encoder: ratio from resolution, pitch
// R10: Converter linear encoder: ratio from scale pitch
// R11: Division remainder carries into next reference
// R12: Latch parameters and check ratio at start-up
module egs_scaler
	import egs_pkg::*;
#(
	parameter int MULT_W = 8
) (
	input  wire logic              clock,
	input  wire logic              reset,
	input  wire egs_bus_t          bus,
	output logic [31:0]            reg_rdata,
	input  wire logic              ref_pulse,
	input  wire logic              ref_dir,
	output logic                   ref_ready,
	input  wire logic [1:0]        enc_sel,
	output egs_fb_t                fb,
	output logic                   gear_alarm,
	output logic                   irq
);

	// ****************************************************************
	// Sizes
	// ****************************************************************
	localparam int DIV_W = 32 + MULT_W;
	localparam int LAT   = DIV_W + 1;

	// Multiplier field must fit the control register
	if (MULT_W < 1 || MULT_W > 8) begin : g_bad_mult
		$error("MULT_W must be 1 to 8");
	end

	// ****************************************************************
	// State
	// ****************************************************************
	typedef struct packed {
		egs_state_e_t      st;
		logic [31:0]       num_set;
		logic [31:0]       den_set;
		logic              men_set;
		logic [MULT_W-1:0] mn_set;
		logic [30:0]       num_act;
		logic [30:0]       den_act;
		logic [MULT_W-1:0] n_act;
		logic              ok;
		logic [31:0]       enc_res;
		logic [30:0]       rem;
		logic [30:0]       rem_start;
		logic [DIV_W-2:0]  prod;
		logic [DIV_W-1:0]  dvd;
		logic [DIV_W-1:0]  quot;
		logic [30:0]       part;
		logic [5:0]        cnt;
		logic              dir;
		logic [IRQ_W-1:0]  ists;
		logic [IRQ_W-1:0]  imask;
		logic              irq;
		logic              alarm;
		logic              ready;
		egs_fb_t           fb;
		logic [31:0]       rdata;
	} egs_regs_t;

	egs_regs_t s_r;
	egs_regs_t s_nxt;

	// Range check of a ratio B/A and of each parameter
	function automatic logic ratio_ok(input logic [31:0] b, input logic [31:0] a);
		logic [63:0] b64;
		logic [63:0] a64;
		b64 = {32'h0000_0000, b};
		a64 = {32'h0000_0000, a};
		return (b != 32'h0) && (a != 32'h0) && (b <= PARAM_MAX) && (a <= PARAM_MAX)
			&& (b64 * RATIO_LO_MUL >= a64) && (b64 <= a64 * RATIO_HI_MUL);
	endfunction : ratio_ok

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb begin
		logic [IRQ_W-1:0] ev;
		logic [IRQ_W-1:0] clr;
		logic [31:0]      trial;
		logic             ge;
		logic [30:0]      newpart;
		logic [DIV_W-1:0] q;
		ev      = '0;
		clr     = '0;
		trial   = '0;
		ge      = 1'b0;
		newpart = '0;
		q       = '0;
		s_nxt   = s_r;
		s_nxt.rdata    = 32'h0;
		s_nxt.fb.valid = 1'b0;

		// Register writes; parameters wait for a restart
		if (bus.write) begin
			case (bus.addr)
				OFS_NUM:  s_nxt.num_set = bus.wdata; // [R3]
				OFS_DEN:  s_nxt.den_set = bus.wdata; // [R4]
				OFS_CTRL: begin
					s_nxt.men_set = bus.wdata[CTRL_MEN_BIT];
					s_nxt.mn_set  = bus.wdata[CTRL_N_LSB +: MULT_W];
					if (bus.wdata[CTRL_RESTART_BIT]) begin
						s_nxt.st = ST_CHECK; // [R12]
					end
				end
				OFS_ISTS: clr = bus.wdata[IRQ_W-1:0];
				OFS_IMSK: s_nxt.imask = bus.wdata[IRQ_W-1:0];
				default:  ;
			endcase
		end

		// Register reads, data in the next cycle only
		if (bus.read) begin
			case (bus.addr)
				OFS_NUM:  s_nxt.rdata = s_r.num_set;
				OFS_DEN:  s_nxt.rdata = s_r.den_set;
				OFS_CTRL: begin
					s_nxt.rdata[CTRL_MEN_BIT]            = s_r.men_set;
					s_nxt.rdata[CTRL_N_LSB +: MULT_W]    = s_r.mn_set;
				end
				OFS_STAT: begin
					s_nxt.rdata[STAT_OK_BIT]    = s_r.ok;
					s_nxt.rdata[STAT_ALARM_BIT] = s_r.alarm;
					s_nxt.rdata[STAT_BUSY_BIT]  = (s_r.st != ST_IDLE);
				end
				OFS_ENC:  s_nxt.rdata = s_r.enc_res;
				OFS_ISTS: s_nxt.rdata[IRQ_W-1:0] = s_r.ists;
				OFS_IMSK: s_nxt.rdata[IRQ_W-1:0] = s_r.imask;
				default:  s_nxt.rdata = 32'h0;
			endcase
		end

		// Reference pulse that cannot be taken
		if (ref_pulse && !s_r.ready) begin
			ev[IRQ_DROP] = 1'b1;
		end

		// Main sequence
		case (s_r.st)
			ST_CHECK: begin
				s_nxt.num_act = s_r.num_set[30:0]; // [R12]
				s_nxt.den_act = s_r.den_set[30:0]; // [R12]
				s_nxt.n_act   = s_r.men_set ? s_r.mn_set : MULT_W'(1); // [R6]
				s_nxt.ok      = ratio_ok(s_r.num_set, s_r.den_set)
					&& (!s_r.men_set || s_r.mn_set != '0); // [R2] [R3] [R4]
				ev[IRQ_ALARM] = !s_nxt.ok; // [R2]
				s_nxt.enc_res = egs_enc_res(enc_sel); // [R8]
				s_nxt.rem     = '0;
				s_nxt.st      = ST_IDLE;
			end
			ST_IDLE: begin
				// One pulse is one unit, scaled by n then by B over A
				if (ref_pulse && s_r.ready) begin // [R5]
					s_nxt.prod      = (DIV_W-1)'(s_r.num_act * s_r.n_act); // [R6]
					s_nxt.rem_start = s_r.rem;
					s_nxt.dir       = ref_dir;
					s_nxt.dvd       = DIV_W'(s_nxt.prod) + DIV_W'(ref_dir
						? s_r.den_act - 31'h1 - s_r.rem : s_r.rem); // [R11]
					s_nxt.quot      = '0;
					s_nxt.part      = '0;
					s_nxt.cnt       = 6'(DIV_W - 1);
					s_nxt.st        = ST_DIV;
				end
			end
			ST_DIV: begin
				// Restoring division, one quotient bit a cycle
				trial   = {s_r.part, s_r.dvd[DIV_W-1]};
				ge      = trial >= {1'b0, s_r.den_act};
				newpart = ge ? 31'(trial - {1'b0, s_r.den_act}) : trial[30:0];
				q       = {s_r.quot[DIV_W-2:0], ge};
				s_nxt.part = newpart;
				s_nxt.quot = q;
				s_nxt.dvd  = {s_r.dvd[DIV_W-2:0], 1'b0};
				if (s_r.cnt == 6'h00) begin
					s_nxt.fb.valid = 1'b1; // [R1]
					s_nxt.fb.dir   = s_r.dir;
					s_nxt.fb.count = q[31:0]; // [R1]
					s_nxt.rem      = s_r.dir ? s_r.den_act - 31'h1 - newpart : newpart; // [R11]
					s_nxt.st       = ST_IDLE;
				end else begin
					s_nxt.cnt = s_r.cnt - 6'h01;
				end
			end
			default: s_nxt.st = ST_CHECK;
		endcase

		// Outputs; gearing only with a good ratio
		s_nxt.ready = (s_nxt.st == ST_IDLE) && s_nxt.ok; // [R2]
		s_nxt.alarm = !s_nxt.ok;
		// Sticky events, a new event beats the clear
		s_nxt.ists  = (s_r.ists & ~clr) | ev;
		s_nxt.irq   = |(s_nxt.ists & s_nxt.imask);
	end

	// ****************************************************************
	// Registers
	// ****************************************************************
	always_ff @(posedge clock) begin
		if (reset) begin
			s_r         <= '0;
			s_r.st      <= ST_CHECK; // [R12]
			s_r.num_set <= NUM_RST; // [R3]
			s_r.den_set <= DEN_RST; // [R4]
			s_r.mn_set  <= MULT_W'(1);
			s_r.ok      <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	// Ports straight from the state flops
	assign reg_rdata  = s_r.rdata;
	assign ref_ready  = s_r.ready;
	assign fb         = s_r.fb;
	assign gear_alarm = s_r.alarm;
	assign irq        = s_r.irq;

	// ****************************************************************
	// Checks
	// ****************************************************************
	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);

	// Gearing only with a good ratio
	ready_gate_a: assert property (s_r.ready |-> s_r.ok && s_r.st == ST_IDLE) // [R2]
		else $error("ready without good ratio");
	alarm_block_a: assert property (s_r.alarm |-> !s_r.fb.valid && !s_r.ready) // [R2]
		else $error("output while ratio alarmed");
	check_verdict_a: assert property (s_r.st == ST_CHECK |=>
		s_r.alarm == !(ratio_ok($past(s_r.num_set), $past(s_r.den_set))
		&& (!$past(s_r.men_set) || $past(s_r.mn_set) != '0))) // [R2]
		else $error("wrong ratio verdict");
	fb_latency_a: assert property (ref_pulse && s_r.ready |-> ##LAT s_r.fb.valid) // [R5]
		else $error("feedback count late or missing");
	// Scaling arithmetic and carry
	scale_sum_a: assert property (s_r.fb.valid |->
		64'(s_r.fb.count) * 64'(s_r.den_act)
		+ 64'(s_r.dir ? s_r.den_act - 31'h1 - s_r.rem : s_r.rem)
		== 64'(s_r.prod)
		+ 64'(s_r.dir ? s_r.den_act - 31'h1 - s_r.rem_start : s_r.rem_start)) // [R1]
		else $error("scaled count does not balance");
	rem_bound_a: assert property (s_r.st != ST_CHECK && s_r.ok |-> s_r.rem < s_r.den_act) // [R11]
		else $error("remainder not below denominator");
	unit_mult_a: assert property (ref_pulse && s_r.ready |=>
		64'(s_r.prod) == 64'(s_r.num_act) * 64'(s_r.n_act)) // [R6]
		else $error("unit product wrong");
	// Settings held until restart
	reset_defaults_a: assert property ($past(reset) |->
		s_r.num_set == NUM_RST && s_r.den_set == DEN_RST) // [R3] [R4]
		else $error("parameter defaults wrong");
	latch_hold_a: assert property (s_r.st != ST_CHECK && $past(s_r.st) != ST_CHECK |->
		$stable(s_r.num_act) && $stable(s_r.den_act)) // [R12]
		else $error("active ratio changed without restart");
	enc_res_a: assert property (s_r.st == ST_CHECK |=>
		s_r.enc_res == egs_enc_res($past(enc_sel))) // [R8]
		else $error("encoder resolution not latched");
	irq_level_a: assert property (s_r.irq == |(s_r.ists & s_r.imask))
		else $error("interrupt level wrong");

	// One reference at a time, result flagged once
	ready_drop_a: assert property (ref_pulse && s_r.ready |=> !s_r.ready) // [R5]
		else $error("second reference taken while busy");
	dir_copy_a: assert property (ref_pulse && s_r.ready |=> // [R1]
		s_r.dir == $past(ref_dir))
		else $error("direction not captured with reference");
	fb_pulse_a: assert property (s_r.fb.valid |=> !s_r.fb.valid) // [R1]
		else $error("result flag longer than one cycle");
	fb_hold_a: assert property (!s_r.fb.valid && !$past(reset) |-> // [R1]
		$stable(s_r.fb.count) && $stable(s_r.fb.dir))
		else $error("result changed between references");

	// Restart side effects
	mult_latch_a: assert property (s_r.st == ST_CHECK |=> // [R6]
		s_r.n_act == ($past(s_r.men_set) ? $past(s_r.mn_set) : MULT_W'(1)))
		else $error("multiplier not latched");
	rem_zero_a: assert property (s_r.st == ST_CHECK |=> s_r.rem == '0) // [R12]
		else $error("carried remainder not cleared");
	alarm_event_a: assert property (s_r.st == ST_CHECK ##1 s_r.alarm |-> // [R2]
		s_r.ists[IRQ_ALARM])
		else $error("alarm event not recorded");

	// Main scenarios
	fwd_ref_c: cover property (ref_pulse && s_r.ready && !ref_dir ##LAT s_r.fb.valid);
	rev_ref_c: cover property (ref_pulse && s_r.ready && ref_dir ##LAT s_r.fb.valid);
	alarm_c: cover property (s_r.st == ST_CHECK ##1 s_r.alarm);
	drop_c: cover property (ref_pulse && !s_r.ready && s_r.st == ST_DIV);
	restart_c: cover property (bus.write && bus.addr == OFS_CTRL
		&& bus.wdata[CTRL_RESTART_BIT] ##1 s_r.st == ST_CHECK);

endmodule : egs_scaler

// ===== sim/egs_host.sv
`timescale 1ns/1ps
// ****************************************************************
// Host pulse source
// ****************************************************************
module egs_host (
	input  wire logic clock,
	input  wire logic reset,
	input  wire logic go,
	input  wire logic go_dir,
	input  wire logic rude,
	input  wire logic ref_ready,
	output logic      ref_pulse,
	output logic      ref_dir
);
	logic pend;
	logic want;
	// One-cycle pulse per request, sent only while ready; rude ignores ready
	always @(posedge clock) begin
		if (reset) begin
			pend <= 1'b0;
			ref_pulse <= 1'b0;
			ref_dir <= 1'b0;
		end else begin
			if (go) begin
				pend <= 1'b1;
				want <= go_dir;
			end
			if (rude) begin
				ref_pulse <= 1'b1;
				ref_dir <= go_dir;
			end else if (pend && ref_ready && !ref_pulse) begin
				ref_pulse <= 1'b1;
				ref_dir <= want;
				pend <= 1'b0;
			end else begin
				ref_pulse <= 1'b0;
				ref_dir <= ~ref_dir; // Direction not held outside a pulse
			end
		end
	end
endmodule : egs_host

// ===== sim/test_electronic_gear_scaler.sv
`timescale 1ns/1ps
module test_electronic_gear_scaler;
	import egs_pkg::*;
	logic        clock = 1'b0;
	logic        reset = 1'b1;
	egs_bus_t    bus = '0;
	logic [31:0] reg_rdata;
	logic        ref_pulse;
	logic        ref_dir;
	logic        ref_ready;
	logic [1:0]  enc_sel = 2'h0;
	egs_fb_t     fb;
	logic        gear_alarm;
	logic        irq;
	logic        go = 1'b0;
	logic        go_dir = 1'b0;
	logic        rude = 1'b0;
	logic [63:0] b = 64'h40;
	logic [63:0] a = 64'h1;
	logic [63:0] n = 64'h1;
	logic [63:0] rem = 64'h0;
	logic [31:0] v;
	int          n_fail = 0;
	int          checks_done = 0;

	always #5 clock = ~clock;

	egs_scaler dut (.clock(clock), .reset(reset), .bus(bus), .reg_rdata(reg_rdata),
		.ref_pulse(ref_pulse), .ref_dir(ref_dir), .ref_ready(ref_ready),
		.enc_sel(enc_sel), .fb(fb), .gear_alarm(gear_alarm), .irq(irq));
	egs_host host (.clock(clock), .reset(reset), .go(go), .go_dir(go_dir), .rude(rude),
		.ref_ready(ref_ready), .ref_pulse(ref_pulse), .ref_dir(ref_dir));

	// ****************************************************************
	// Shared tasks
	// ****************************************************************
	task automatic complete_run;
		$display("checks %0d, mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : complete_run

	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic wr(input logic [7:0] ad, input logic [31:0] d);
		@(posedge clock);
		bus <= '{addr: ad, wdata: d, write: 1'b1, read: 1'b0};
		@(posedge clock);
		bus.write <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] ad);
		@(posedge clock);
		bus <= '{addr: ad, wdata: 32'h0, write: 1'b0, read: 1'b1};
		@(posedge clock);
		bus.read <= 1'b0;
		#1 v = reg_rdata;
	endtask : rd

	// Settings plus restart; model follows the active values
	task automatic set(input logic [31:0] bi, input logic [31:0] ai, input logic [31:0] c);
		wr(OFS_NUM, bi);
		wr(OFS_DEN, ai);
		wr(OFS_CTRL, c | 32'h8000_0000);
		repeat (3) @(posedge clock);
		b = bi;
		a = ai;
		n = c[0] ? c[15:8] : 64'h1;
		rem = 64'h0;
	endtask : set

	// One reference, expected count from carried remainder
	task automatic pulse(input logic d);
		logic [63:0] c;
		int          k;
		if (!d) begin
			c = (rem + b * n) / a;
			rem = (rem + b * n) % a;
		end else begin
			c = (b * n + a - 64'h1 - rem) / a;
			rem = rem + c * a - b * n;
		end
		@(posedge clock);
		go <= 1'b1;
		go_dir <= d;
		@(posedge clock);
		go <= 1'b0;
		for (k = 0; k < 80 && fb.valid !== 1'b1; k++)
			@(posedge clock) #1;
		chk(fb.valid, 1'b1);
		chk(fb.count, c[31:0]);
		chk(fb.dir, d);
	endtask : pulse

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	task automatic t_reset;
		rd(OFS_NUM);
		chk(v, NUM_RST);
		rd(OFS_DEN);
		chk(v, DEN_RST);
		rd(OFS_STAT);
		chk(v, 32'h1);
		rd(OFS_IMSK);
		chk(v, 32'h0);
		rd(8'h1C);
		chk(v, 32'h0);
	endtask : t_reset

	task automatic t_default;
		pulse(1'b0);
		wr(OFS_NUM, 32'h5);
		pulse(1'b0);
	endtask : t_default

	task automatic t_linear;
		int i;
		set(32'd256, 32'd20, 32'h100);
		for (i = 0; i < 6; i++)
			pulse(i > 3);
	endtask : t_linear

	task automatic t_mult;
		set(32'h1, 32'h1, 32'h301);
		rd(OFS_CTRL);
		chk(v, 32'h301);
		pulse(1'b0);
		set(32'h1, 32'h1, 32'h1);
		chk(gear_alarm, 1'b1);
	endtask : t_mult

	task automatic t_range;
		logic [31:0] tb [7] = '{32'd1, 32'd1, 32'd64000, 32'd64001, 32'd0,
			32'h4000_0001, 32'h4000_0000};
		logic [31:0] ta [7] = '{32'd1000, 32'd1001, 32'd1, 32'd1, 32'd1,
			32'h4000_0000, 32'h4000_0000};
		logic        ok [7] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1};
		int          i;
		for (i = 0; i < 7; i++) begin
			set(tb[i], ta[i], 32'h100);
			chk(gear_alarm, !ok[i]);
			rd(OFS_STAT);
			chk(v, ok[i] ? 32'h1 : 32'h2);
			chk(ref_ready, ok[i]);
		end
	endtask : t_range

	task automatic t_irq;
		wr(OFS_ISTS, 32'h3);
		set(32'h1, 32'd1001, 32'h100);
		rd(OFS_ISTS);
		chk(v, 32'h1);
		chk(irq, 1'b0);
		wr(OFS_IMSK, 32'h3);
		@(posedge clock) #1;
		chk(irq, 1'b1);
		wr(OFS_ISTS, 32'h1);
		@(posedge clock) #1;
		chk(irq, 1'b0);
		@(posedge clock);
		rude <= 1'b1;
		@(posedge clock);
		rude <= 1'b0;
		rd(OFS_ISTS);
		chk(v, 32'h2);
		chk(irq, 1'b1);
		wr(OFS_ISTS, 32'h2);
		wr(OFS_IMSK, 32'h0);
	endtask : t_irq

	task automatic t_enc;
		int i;
		for (i = 0; i < 4; i++) begin
			@(posedge clock);
			enc_sel <= i[1:0];
			set(32'h1, 32'h1, 32'h100);
			rd(OFS_ENC);
			chk(v, i == 1 ? RES_22 : i == 2 ? RES_24 : RES_20);
		end
	endtask : t_enc

	// ****************************************************************
	// Main sequence and watchdog
	// ****************************************************************
	initial begin
		repeat (10) @(posedge clock);
		reset <= 1'b0;
		repeat (2) @(posedge clock);
		t_reset();
		t_default();
		t_linear();
		t_mult();
		t_range();
		t_irq();
		t_enc();
		complete_run();
	end

	initial begin
		#300000;
		n_fail++;
		complete_run();
	end
endmodule : test_electronic_gear_scaler
